/* logic/line_interface_global_control.sv */
// apb register bank for the eight channel line interface global controls
`timescale 1ns/10ps
`default_nettype none
`include "line_ctl_map.svh"

// How it works
// - auto all-ones select register clears to zero at reset, feature off.
// - select bit set and channel signal loss starts transmit all-ones there.
// - auto all-ones ignored while master clock and transmit clock both held high.
// - global bit 6 enables alarm pattern replacing receive pos/neg data on loss.
// - no receive alarm insertion while master clock is held high.
// - global bit 5 zero keeps short-circuit protection on, one turns it off.
// - global bit 4 zero picks HDB3/B8ZS, one picks plain AMI.
// - zero suppression applies only with unipolar system data.
// - global bit 3 picks jitter attenuator depth 32 or 64 bits.
// - global bit 2 picks one of two jitter attenuator corner frequencies.
// - global bits 1:0 with low bit zero disable attenuator; 01 puts it in transmit.
// - pointer low three bits select channel 0 to 7 directly.
// - shaping data reads and writes reach the pointed channel's storage.
// - line length code zero is E1, codes three to seven are T1 shapes.
// - reading back a line length code returns its bits inverted.
module line_interface_global_control (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [9:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_MCLK_HELD_HIGH,
  input wire logic [7:0] I_TX_CLOCK_IN_HIGH,
  input wire logic [7:0] I_SIGNAL_LOSS,
  input wire logic I_SYS_UNIPOLAR,
  input wire logic [7:0] I_RX_POS,
  input wire logic [7:0] I_RX_NEG,
  output logic [7:0] O_TRANSMIT_ALL_ONES,
  output logic [7:0] O_RX_ALARM_INSERT,
  output line_ctl_pkg::rx_pair_type O_RX_OUT,
  output line_ctl_pkg::line_cfg_type O_LINE_CFG,
  output logic [23:0] O_LINE_LENGTH_CODE,
  output logic [7:0] O_CHAN_E1,
  output logic [7:0] O_CHAN_T1
);

  // ---- bus decode ----
  logic [7:0] reg_idx;
  line_ctl_pkg::reg_sel_type reg_sel;
  logic setup_phase;
  logic access_phase;
  logic wr_take;

  // index of the word addressed; the two low address bits are ignored
  assign reg_idx = I_PADDR[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
  assign setup_phase = I_PSEL & ~I_PENABLE;
  assign access_phase = I_PSEL & I_PENABLE;
  // only the low byte lane carries register bits
  assign wr_take = access_phase & I_PWRITE & I_PSTRB[0];

  // address to register select
  always_comb begin
    unique case (reg_idx)
      `AUTO_ONES_IDX: begin
        reg_sel = line_ctl_pkg::SEL_AUTO_ONES;
      end
      `GLOBAL_CTL_IDX: begin
        reg_sel = line_ctl_pkg::SEL_GLOBAL;
      end
      `CHAN_PTR_IDX: begin
        reg_sel = line_ctl_pkg::SEL_PTR;
      end
      `SHAPING_DATA_IDX: begin
        reg_sel = line_ctl_pkg::SEL_SHAPING;
      end
      default: begin
        reg_sel = line_ctl_pkg::SEL_NONE;
      end
    endcase
  end

  // zero wait states: every access completes in its first access cycle
  assign O_PREADY = 1'b1;
  // unmapped words answer with an error and read as zero
  assign O_PSLVERR = access_phase & (reg_sel == line_ctl_pkg::SEL_NONE);

  // ---- register state ----
  logic [7:0] auto_ones_r;
  logic [7:0] auto_ones_nxt;
  logic [7:0] global_r;
  logic [7:0] global_nxt;
  logic [2:0] ptr_r;
  logic [2:0] ptr_nxt;
  logic [2:0] line_length_r [8];
  logic [2:0] line_length_nxt [8];
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // register writes and the read data word
  always_comb begin
    auto_ones_nxt = auto_ones_r;
    global_nxt = global_r;
    ptr_nxt = ptr_r;
    for (int i = 0; i < 8; i++) begin
      line_length_nxt[i] = line_length_r[i];
    end
    prdata_nxt = prdata_r;
    if (wr_take) begin
      unique case (reg_sel)
        line_ctl_pkg::SEL_AUTO_ONES: begin
          auto_ones_nxt = I_PWDATA[7:0];
        end
        line_ctl_pkg::SEL_GLOBAL: begin
          // reserved bit 7 stays zero
          global_nxt = {1'b0, I_PWDATA[`GC_USED_MSB:0]};
        end
        line_ctl_pkg::SEL_PTR: begin
          // low three bits pick the channel
          ptr_nxt = I_PWDATA[`PTR_MSB:0];
        end
        line_ctl_pkg::SEL_SHAPING: begin
          line_length_nxt[ptr_r] = I_PWDATA[2:0];
        end
        line_ctl_pkg::SEL_NONE: begin
          prdata_nxt = prdata_r;
        end
      endcase
    end
    // read word is built in the setup cycle so it stands through access
    if (setup_phase) begin
      prdata_nxt = 32'h0000_0000;
      if (!I_PWRITE) begin
        unique case (reg_sel)
          line_ctl_pkg::SEL_AUTO_ONES: begin
            prdata_nxt[7:0] = auto_ones_r;
          end
          line_ctl_pkg::SEL_GLOBAL: begin
            prdata_nxt[7:0] = global_r;
          end
          line_ctl_pkg::SEL_PTR: begin
            prdata_nxt[`PTR_MSB:0] = ptr_r;
          end
          line_ctl_pkg::SEL_SHAPING: begin
            prdata_nxt[2:0] = ~line_length_r[ptr_r];
          end
          line_ctl_pkg::SEL_NONE: begin
            prdata_nxt = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // register bank flops
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      auto_ones_r <= `AUTO_ONES_RST;
      global_r <= `GLOBAL_CTL_RST;
      ptr_r <= `CHAN_PTR_RST;
      for (int i = 0; i < 8; i++) begin
        line_length_r[i] <= `LINE_LENGTH_RST;
      end
      prdata_r <= 32'h0000_0000;
    end else begin
      auto_ones_r <= auto_ones_nxt;
      global_r <= global_nxt;
      ptr_r <= ptr_nxt;
      for (int i = 0; i < 8; i++) begin
        line_length_r[i] <= line_length_nxt[i];
      end
      prdata_r <= prdata_nxt;
    end
  end

  assign O_PRDATA = prdata_r;

  // ---- line side controls ----
  logic [7:0] all_ones_nxt;
  logic [7:0] all_ones_r;
  logic [7:0] alarm_ins_nxt;
  logic [7:0] alarm_ins_r;
  line_ctl_pkg::rx_pair_type rx_nxt;
  line_ctl_pkg::rx_pair_type rx_r;
  line_ctl_pkg::line_cfg_type cfg_nxt;
  line_ctl_pkg::line_cfg_type cfg_r;
  logic [23:0] code_nxt;
  logic [23:0] code_r;
  logic [7:0] e1_nxt;
  logic [7:0] e1_r;
  logic [7:0] t1_nxt;
  logic [7:0] t1_r;

  // per-channel alarm actions and modes; outputs lag inputs by one clock
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      all_ones_nxt[n] = auto_ones_r[n] & I_SIGNAL_LOSS[n]
        & ~(I_MCLK_HELD_HIGH & I_TX_CLOCK_IN_HIGH[n]);
      alarm_ins_nxt[n] = global_r[`GC_RX_ALARM_BIT] & I_SIGNAL_LOSS[n]
        & ~I_MCLK_HELD_HIGH;
      // all-ones pattern shown as marks on the positive rail
      rx_nxt.pos[n] = alarm_ins_nxt[n] ? 1'b1 : I_RX_POS[n];
      rx_nxt.neg[n] = alarm_ins_nxt[n] ? 1'b0 : I_RX_NEG[n];
      code_nxt[3*n +: 3] = line_length_r[n];
      // zero is E1, three up T1
      e1_nxt[n] = (line_length_r[n] == `LINE_LENGTH_E1);
      t1_nxt[n] = (line_length_r[n] >= `LINE_LENGTH_T1_MIN);
    end
  end

  // global configuration decode
  always_comb begin
    cfg_nxt.short_protect_en = ~global_r[`GC_SHORT_OFF_BIT];
    cfg_nxt.line_code_ami = global_r[`GC_CODE_BIT];
    cfg_nxt.zero_suppress_en = ~global_r[`GC_CODE_BIT] & I_SYS_UNIPOLAR;
    cfg_nxt.ja_depth_64 = global_r[`GC_DEPTH_BIT];
    cfg_nxt.ja_corner = global_r[`GC_CORNER_BIT];
    cfg_nxt.ja_in_tx = global_r[`GC_JA_LO_BIT] & ~global_r[`GC_JA_HI_BIT];
    cfg_nxt.ja_in_rx = global_r[`GC_JA_LO_BIT] & global_r[`GC_JA_HI_BIT];
  end

  // line side output flops
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      all_ones_r <= 8'h00;
      alarm_ins_r <= 8'h00;
      rx_r <= '0;
      cfg_r <= '0;
      code_r <= 24'h00_0000;
      e1_r <= 8'h00;
      t1_r <= 8'h00;
    end else begin
      all_ones_r <= all_ones_nxt;
      alarm_ins_r <= alarm_ins_nxt;
      rx_r <= rx_nxt;
      cfg_r <= cfg_nxt;
      code_r <= code_nxt;
      e1_r <= e1_nxt;
      t1_r <= t1_nxt;
    end
  end

  // all line side outputs come straight from flops
  assign O_TRANSMIT_ALL_ONES = all_ones_r;
  assign O_RX_ALARM_INSERT = alarm_ins_r;
  assign O_RX_OUT = rx_r;
  assign O_LINE_CFG = cfg_r;
  assign O_LINE_LENGTH_CODE = code_r;
  assign O_CHAN_E1 = e1_r;
  assign O_CHAN_T1 = t1_r;

endmodule
`default_nettype wire

/* logic/line_ctl_map.svh */
// register indices, field positions and reset values of the line control bank
`ifndef LINE_CTL_MAP_SVH
`define LINE_CTL_MAP_SVH

// register indices; the byte address is four times the index
`define AUTO_ONES_IDX 8'h0E
`define GLOBAL_CTL_IDX 8'h0F
`define CHAN_PTR_IDX 8'h10
`define SHAPING_DATA_IDX 8'h11

// reset values
`define AUTO_ONES_RST 8'h00
`define GLOBAL_CTL_RST 8'h00
`define CHAN_PTR_RST 3'h0
`define LINE_LENGTH_RST 3'h0

// global control fields
`define GC_RX_ALARM_BIT 6
`define GC_SHORT_OFF_BIT 5
`define GC_CODE_BIT 4
`define GC_DEPTH_BIT 3
`define GC_CORNER_BIT 2
`define GC_JA_HI_BIT 1
`define GC_JA_LO_BIT 0
`define GC_USED_MSB 6

// line length codes
`define LINE_LENGTH_E1 3'h0
`define LINE_LENGTH_T1_MIN 3'h3

// bus field positions
`define ADDR_IDX_MSB 9
`define ADDR_IDX_LSB 2
`define PTR_MSB 2

`endif

/* logic/line_ctl_pkg.sv */
// types shared by the line control bank
package line_ctl_pkg;

  // configuration that the register bank hands to the line datapath
  typedef struct packed {
    logic short_protect_en;
    logic line_code_ami;
    logic zero_suppress_en;
    logic ja_depth_64;
    logic ja_corner;
    logic ja_in_tx;
    logic ja_in_rx;
  } line_cfg_type;

  // per-channel receive pair after alarm insertion
  typedef struct packed {
    logic [7:0] pos;
    logic [7:0] neg;
  } rx_pair_type;

  // decoded target of an apb access
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_AUTO_ONES = 3'b001,
    SEL_GLOBAL = 3'b010,
    SEL_PTR = 3'b011,
    SEL_SHAPING = 3'b100
  } reg_sel_type;

endpackage

/* dv/line_ctl_chk.sv */
// port assertions for the line control register bank
`timescale 1ns/10ps
`default_nettype none
`include "line_ctl_map.svh"
module line_ctl_chk (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [9:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic O_PSLVERR,
  input wire logic I_MCLK_HELD_HIGH,
  input wire logic [7:0] I_TX_CLOCK_IN_HIGH,
  input wire logic [7:0] I_SIGNAL_LOSS,
  input wire logic I_SYS_UNIPOLAR,
  input wire logic [7:0] I_RX_POS,
  input wire logic [7:0] I_RX_NEG,
  input wire logic [7:0] O_TRANSMIT_ALL_ONES,
  input wire logic [7:0] O_RX_ALARM_INSERT,
  input wire line_ctl_pkg::rx_pair_type O_RX_OUT,
  input wire line_ctl_pkg::line_cfg_type O_LINE_CFG
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // accepted write to the global control word
  sequence gc_wr;
    I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0] && I_PADDR[9:2] == `GLOBAL_CTL_IDX;
  endsequence
  // a write reaches the line outputs two edges later
  line_cfg_a:
    assert property (gc_wr |-> ##2 O_LINE_CFG[6:5] == {!$past(I_PWDATA[5], 2),
      $past(I_PWDATA[4], 2)}) else $error("protect or code field wrong");
  ja_cfg_a:
    assert property (gc_wr |-> ##2 O_LINE_CFG[3:0] == {$past(I_PWDATA[3:2], 2),
      $past(I_PWDATA[1:0], 2) == 2'b01, $past(I_PWDATA[1:0], 2) == 2'b11})
      else $error("jitter attenuator fields wrong");
  zero_supp_a:
    assert property ($past(I_NRST) |-> O_LINE_CFG.zero_suppress_en ==
      (!O_LINE_CFG.line_code_ami && $past(I_SYS_UNIPOLAR))) else $error("zero suppression wrong");
  ones_loss_a:
    assert property ((O_TRANSMIT_ALL_ONES & ~$past(I_SIGNAL_LOSS)) == 8'h00)
      else $error("all ones without loss");
  ones_mask_a:
    assert property ($past(I_MCLK_HELD_HIGH) |->
      (O_TRANSMIT_ALL_ONES & $past(I_TX_CLOCK_IN_HIGH)) == 8'h00) else $error("all ones unmasked");
  ins_mask_a:
    assert property ($past(I_MCLK_HELD_HIGH) |-> O_RX_ALARM_INSERT == 8'h00)
      else $error("insert in recovery mode");
  ins_loss_a:
    assert property ((O_RX_ALARM_INSERT & ~$past(I_SIGNAL_LOSS)) == 8'h00)
      else $error("insert without loss");
  rx_path_a:
    assert property ($past(I_NRST) |-> O_RX_OUT == {$past(I_RX_POS) | O_RX_ALARM_INSERT,
      $past(I_RX_NEG) & ~O_RX_ALARM_INSERT}) else $error("receive outputs wrong");
  // unmapped words answer with an error, mapped ones never do
  err_map_a:
    assert property (I_PSEL && I_PENABLE |-> O_PSLVERR ==
      !(I_PADDR[9:2] inside {[`AUTO_ONES_IDX:`SHAPING_DATA_IDX]})) else $error("slave error wrong");
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the line control register bank
`timescale 1ns/10ps
`default_nettype none
`include "line_ctl_map.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [9:0] padr = 10'h000;
  logic [31:0] pwd = 32'h00000000;
  logic [3:0] pstb = 4'hF;
  logic mclk = 1'b0;
  logic uni = 1'b1;
  logic [7:0] txh = 8'h00, signal_loss = 8'h00, rxp = 8'h00, rxn = 8'h00;
  logic [31:0] prd, rd;
  logic prdy, perr, slv;
  logic [7:0] transmit_all_ones, ins, e1, t1;
  logic [23:0] len;
  line_ctl_pkg::rx_pair_type rxo;
  line_ctl_pkg::line_cfg_type cfg;
  int err_count = 0;
  int n_tests = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  line_interface_global_control line_interface_global_control_i (.I_CLK(clk), .I_NRST(nrst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
    .I_PSTRB(pstb), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .I_MCLK_HELD_HIGH(mclk), .I_TX_CLOCK_IN_HIGH(txh), .I_SIGNAL_LOSS(signal_loss),
    .I_SYS_UNIPOLAR(uni), .I_RX_POS(rxp), .I_RX_NEG(rxn), .O_TRANSMIT_ALL_ONES(transmit_all_ones),
    .O_RX_ALARM_INSERT(ins), .O_RX_OUT(rxo), .O_LINE_CFG(cfg), .O_LINE_LENGTH_CODE(len),
    .O_CHAN_E1(e1), .O_CHAN_T1(t1));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; ready is awaited under a bound, never assumed
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {idx, 2'b00};
    pwd <= d;
    pstb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 16);
    rd = prd;
    slv = perr;
    chk("ready", {31'h0, prdy}, 32'h00000001);
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 16) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // register writes reach the line side two edges on
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
  endtask
  // run after a mid-run reset so stale values would show
  task automatic scen_reset;
    apb(0, `AUTO_ONES_IDX, 0, 4'hF);
    chk("auto ones", rd, 0);
    apb(0, `CHAN_PTR_IDX, 0, 4'hF);
    chk("pointer", rd, 0);
    apb(0, `SHAPING_DATA_IDX, 0, 4'hF);
    chk("shaping", rd, 32'h00000007);
    apb(1, 8'h20, 32'h000000FF, 4'hF);
    apb(0, 8'h20, 0, 4'hF);
    chk("unmapped", {rd[30:0], slv}, 1);
  endtask
  task automatic scen_ones;
    apb(1, `AUTO_ONES_IDX, 32'h000000A5, 4'hF);
    apb(1, `AUTO_ONES_IDX, 32'h000000FF, 4'hE);
    apb(0, `AUTO_ONES_IDX, 0, 4'hF);
    chk("ones reg", rd, 32'h000000A5);
    signal_loss <= 8'hFF;
    txh <= 8'h0F;
    settle;
    chk("ones", transmit_all_ones, 32'h000000A5);
    mclk <= 1'b1;
    settle;
    chk("ones masked", transmit_all_ones, 32'h000000A0);
    mclk <= 1'b0;
    signal_loss <= 8'h00;
  endtask
  task automatic scen_global;
    logic [7:0] v[5] = '{8'hFF, 8'h01, 8'h02, 8'h03, 8'h14};
    logic [6:0] e;
    foreach (v[i]) begin
      apb(1, `GLOBAL_CTL_IDX, {24'h0, v[i]}, 4'hF);
      apb(0, `GLOBAL_CTL_IDX, 0, 4'hF);
      chk("global rd", rd, {25'h0, v[i][6:0]});
      uni <= v[i][0];
      settle;
      e = {~v[i][5], v[i][4], ~v[i][4] & v[i][0], v[i][3:2], v[i][1:0] == 2'b01, &v[i][1:0]};
      chk("line cfg", cfg, e);
    end
  endtask
  task automatic scen_alarm;
    rxp <= 8'h3C;
    rxn <= 8'hC3;
    signal_loss <= 8'h0F;
    // alarm interrupts live elsewhere; none to mask here
    apb(1, `GLOBAL_CTL_IDX, 32'h00000040, 4'hF);
    settle;
    chk("insert rx", {ins, rxo}, 32'h000F3FC0);
    mclk <= 1'b1;
    settle;
    chk("insert off", {ins, rxo}, 32'h00003CC3);
    mclk <= 1'b0;
    signal_loss <= 8'h00;
  endtask
  task automatic scen_shaping;
    for (int c = 0; c < 8; c++) begin
      apb(1, `CHAN_PTR_IDX, {27'h0, 2'h3, c[2:0]}, 4'hF);
      apb(1, `SHAPING_DATA_IDX, c, 4'hF);
    end
    for (int c = 0; c < 8; c++) begin
      apb(1, `CHAN_PTR_IDX, c, 4'hF);
      apb(0, `CHAN_PTR_IDX, 0, 4'hF);
      chk("pointer", rd, c);
      apb(0, `SHAPING_DATA_IDX, 0, 4'hF);
      chk("shaping rd", rd, 7 - c);
    end
    settle;
    chk("codes", len, 32'h00FAC688);
    chk("modes", {e1, t1}, 32'h000001F8);
  endtask
  initial begin
    do_reset();
    scen_ones();
    scen_global();
    scen_alarm();
    scen_shaping();
    do_reset();
    scen_reset();
    report_and_stop();
  end
endmodule
bind line_interface_global_control line_ctl_chk line_ctl_chk_i (.*);
`default_nettype wire
